// *** design/mdt_pkg.sv ***
// constants for the diagnostic counter and object-dictionary transport block
// assumes: byte-wide pdu streams, 32-bit avalon-mm register bus, one clock
package mdt_pkg;
	// ****************************************
	// frame codes
	// ****************************************
	localparam logic [7:0]  FC_DIAG    = 8'h08;
	localparam logic [7:0]  FC_MEI     = 8'h2b;
	localparam logic [7:0]  MEI_OD     = 8'h0d;
	localparam logic [7:0]  EXC_FLAG   = 8'h80;
	localparam logic [7:0]  EXC_EXT    = 8'hff;
	localparam logic [15:0] EXC_LEN    = 16'h0006;
	localparam logic [7:0]  EXC_OD     = 8'hce;
	localparam logic [31:0] ERR_FMT    = 32'hffff0003;
	localparam logic [15:0] SUB_CLEAR  = 16'h000a;
	localparam logic [15:0] SUB_BUSY   = 16'h0011;
	localparam logic [15:0] SUB_OVR    = 16'h0012;
	localparam logic [7:0]  NODE_MAX   = 8'h7f;
	localparam logic [15:0] CNT_MAX    = 16'h00fd;
	// ****************************************
	// protocol control, byte bit positions (msb is field bit 0)
	// ****************************************
	localparam int          PCB_MULTI  = 7;
	localparam int          PCB_EXT    = 6;
	localparam int          PCB_CNT    = 5;
	localparam int          PCB_WR     = 0;
	localparam logic [3:0]  PC_RSV_MSK = 4'hf;
	// ****************************************
	// frame layout
	// ****************************************
	localparam int          HDR_N      = 14;
	localparam logic [3:0]  PC_POS     = 4'd3;
	localparam logic [3:0]  FLD_SPAN   = 4'd8;
	localparam logic [7:0]  DIAG_LEN   = 8'd5;
	localparam logic [3:0]  DIAG_RLEN  = 4'd5;
	localparam logic [3:0]  EXC_RLEN   = 4'd10;
	// ****************************************
	// registers
	// ****************************************
	localparam logic [4:0]  REG_CTRL   = 5'h00;
	localparam logic [4:0]  REG_BUSY   = 5'h04;
	localparam logic [4:0]  REG_OVR    = 5'h08;
	localparam logic [4:0]  REG_STAT   = 5'h0c;
	localparam logic [4:0]  REG_MASK   = 5'h10;
	localparam logic [4:0]  REG_LAST   = 5'h14;
	localparam int          CTRL_EN    = 0;
	localparam int          CTRL_CLR   = 1;
	localparam logic        CTRL_EN_RST = 1'b1;
	localparam int          IRQ_W      = 3;
	localparam int          IRQ_OVR    = 0;
	localparam int          IRQ_ERR    = 1;
	localparam int          IRQ_REQ    = 2;
	localparam logic [2:0]  MASK_RST   = 3'h0;
	typedef enum logic [2:0] {ST_RX, ST_EVAL, ST_OD, ST_HDR, ST_DAT} mdt_state_e;
endpackage

// *** design/mdt_wrap_cnt.sv ***
// 16-bit event counter that wraps and clears
// assumes: inc and clear are pulses on clk_in
`timescale 1ns/1ps
module mdt_wrap_cnt #(
	parameter int W = 16
) (
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire logic         clr_in,
	input  wire logic         inc_in,
	output logic [W-1:0]      cnt_out
);
	// clear beats a same-cycle step so a restart always reads back zero
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_out <= '0;
		end else if (clr_in) begin
			cnt_out <= '0;
		end else if (inc_in) begin
			cnt_out <= cnt_out + W'(1); // wraps to zero past all ones
		end
	end
endmodule // mdt_wrap_cnt

// *** design/mdt_transport.sv ***
// diagnostic counters and object-dictionary transport for a field-bus server
// assumes: rx carries pdus already addressed to us, crc checked and stripped
//
// Contract
// - subfunction 0011h returns count of busy exception replies
// - counters zero at power-on, restart and clear-counters request
// - subfunction 0012h returns count of messages lost to character overrun
// - overrun is a byte arriving before stored, or a lost character
// - diagnostic reply echoes function and two-byte subfunction, then data
// - transport frame: address, 2Bh, 0Dh, options, address/data, crc
// - options: control field, zero reserved byte, optional counter byte
// - control bits numbered from msb: bit 0 top of first byte
// - control bit 0 marks one part of a multi-message data set
// - control bit 1 selects one or two control bytes
// - control bit 2 says counter byte is present
// - control bit 7 gives access direction: zero read, one write
// - node, index, subindex, start, count up to 00fdh, data, high first
// - transport frames read and write object dictionary entries
// - transport failure replies abh, ffh, length, 0dh, ceh, error code
`timescale 1ns/1ps
module mdt_transport (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic [4:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic [3:0]  avs_byteenable_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic             irq_out,
	input  wire logic        rx_valid_in,
	input  wire logic [7:0]  rx_data_in,
	input  wire logic        rx_last_in,
	output logic             rx_ready_out,
	input  wire logic        char_lost_in,
	input  wire logic        restart_in,
	input  wire logic        busy_exc_in,
	output logic             tx_valid_out,
	output logic [7:0]       tx_data_out,
	output logic             tx_last_out,
	input  wire logic        tx_ready_in,
	output logic             od_req_out,
	output logic             od_write_out,
	output logic             od_multi_out,
	output logic [7:0]       od_node_out,
	output logic [15:0]      od_index_out,
	output logic [7:0]       od_sub_out,
	output logic [15:0]      od_start_out,
	output logic [15:0]      od_count_out,
	output logic             od_wr_valid_out,
	output logic [7:0]       od_wr_data_out,
	input  wire logic        od_done_in,
	input  wire logic        od_err_in,
	input  wire logic [31:0] od_err_code_in,
	input  wire logic [15:0] od_rd_len_in,
	input  wire logic        od_rd_valid_in,
	input  wire logic [7:0]  od_rd_data_in,
	output logic             od_rd_ready_out,
	output logic             unhandled_out
);
	import mdt_pkg::*;

	mdt_state_e  st_r;
	logic [7:0]  hdr_r [HDR_N];
	logic [7:0]  rsp_r [HDR_N];
	logic [3:0]  rsp_len_r;
	logic [3:0]  tx_idx_r;
	logic [8:0]  idx_r;
	logic [8:0]  len_r;
	logic [15:0] rd_left_r;
	logic        ovr_pend_r;
	logic        en_r;
	logic        ack_r;
	logic        lost_s1_r;
	logic        lost_s2_r;
	logic        lost_s3_r;
	logic [IRQ_W-1:0] stat_r;
	logic [IRQ_W-1:0] mask_r;
	logic [15:0] cnt_w [2];
	logic [1:0]  inc_w;
	logic        clr_w;
	logic        rx_take;
	logic        ovr_evt;
	logic        bus_wr;
	logic [7:0]  pc1;
	logic        ext;
	logic        cntb;
	logic [3:0]  off;
	logic [3:0]  nb;
	logic [3:0]  hlen;
	logic [15:0] cntv;
	logic        is_diag;
	logic        diag_ok;
	logic [15:0] sub;
	logic        is_od;
	logic        fmt_ok;
	logic        exc_go;
	logic        ok_go;
	logic [31:0] exc_code;

	// ****************************************
	// pin synchroniser and overrun detection
	// ****************************************
	// the lost-character pin is asynchronous; only the second and third stages are read, for the rising edge
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lost_s1_r <= 1'b0;
			lost_s2_r <= 1'b0;
			lost_s3_r <= 1'b0;
		end else begin
			lost_s1_r <= char_lost_in;
			lost_s2_r <= lost_s1_r;
			lost_s3_r <= lost_s2_r;
		end
	end

	// a byte offered while we cannot store it is an overrun, so is a lost one
	assign rx_ready_out = (st_r == ST_RX);
	assign rx_take      = rx_valid_in & rx_ready_out;
	assign ovr_evt      = (rx_valid_in & ~rx_ready_out) | (lost_s2_r & ~lost_s3_r);

	// pending overrun poisons the frame in flight; set wins over the clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ovr_pend_r <= 1'b0;
		end else if (ovr_evt) begin
			ovr_pend_r <= 1'b1;
		end else if (st_r == ST_EVAL) begin
			ovr_pend_r <= 1'b0;
		end
	end

	// ****************************************
	// diagnostic counters
	// ****************************************
	assign inc_w[0] = busy_exc_in;
	assign inc_w[1] = ovr_evt & ~ovr_pend_r;    // one count per lost message
	assign bus_wr   = avs_write_in & ack_r & avs_byteenable_in[0];
	assign clr_w    = restart_in
		| (st_r == ST_EVAL && !ovr_pend_r && diag_ok && sub == SUB_CLEAR)
		| (bus_wr && avs_address_in == REG_CTRL && avs_byteenable_in[0] && avs_writedata_in[CTRL_CLR]);

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cnt
			mdt_wrap_cnt #(.W(16)) u_cnt (
				.clk_in    (clk_in),
				.resetn_in (resetn_in),
				.clr_in    (clr_w),
				.inc_in    (inc_w[g]),
				.cnt_out   (cnt_w[g])
			);
		end
	endgenerate

	// ****************************************
	// frame capture
	// ****************************************
	// header bytes land in flip-flops; later bytes only stream out as write data
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idx_r <= 9'h0;
			len_r <= 9'h0;
			for (int i = 0; i < HDR_N; i++) begin
				hdr_r[i] <= 8'h0;
			end
		end else if (rx_take) begin
			if (idx_r < 9'(HDR_N)) begin
				hdr_r[idx_r[3:0]] <= rx_data_in;
			end
			// nine bits so the longest write, full header plus 253 data bytes, still measures
			if (rx_last_in) begin
				idx_r <= 9'h0;
				len_r <= (idx_r == 9'h1ff) ? 9'h1ff : idx_r + 9'h1;
			end else if (idx_r != 9'h1ff) begin
				idx_r <= idx_r + 9'h1;
			end
		end
	end

	// field offsets follow the extended and counter options
	assign pc1  = hdr_r[PC_POS - 4'd1];
	assign ext  = pc1[PCB_EXT];
	assign cntb = pc1[PCB_CNT];
	assign off  = PC_POS + {3'h0, ext};                     // reserved follows control
	assign nb   = off + 4'd1 + {3'h0, cntb};                // optional counter byte
	assign hlen = nb + FLD_SPAN;
	assign cntv = {hdr_r[nb + 4'd6], hdr_r[nb + 4'd7]};     // high byte first
	assign sub  = {hdr_r[1], hdr_r[2]};

	assign is_diag = (hdr_r[0] == FC_DIAG) && (len_r == {1'b0, DIAG_LEN});
	assign diag_ok = is_diag && (sub == SUB_BUSY || sub == SUB_OVR || sub == SUB_CLEAR);
	assign is_od   = en_r && hdr_r[0] == FC_MEI && hdr_r[1] == MEI_OD;

	// unsupported options and reserved bits refuse the frame
	assign fmt_ok = (pc1[4:1] & PC_RSV_MSK) == 4'h0
		&& (!ext || hdr_r[PC_POS] == 8'h0)
		&& hdr_r[off] == 8'h0
		&& hdr_r[nb] != 8'h0 && hdr_r[nb] <= NODE_MAX
		&& cntv <= CNT_MAX
		&& {7'h0, len_r} == {12'h0, hlen} + (pc1[PCB_WR] ? cntv : 16'h0);

	assign exc_go = (st_r == ST_EVAL && !ovr_pend_r && !diag_ok && is_od && !fmt_ok)
		| (st_r == ST_OD && od_done_in && od_err_in);
	assign ok_go    = st_r == ST_OD && od_done_in && !od_err_in;
	assign exc_code = (st_r == ST_OD) ? od_err_code_in : ERR_FMT;

	// write data bytes stream out as they arrive; od_req_out later confirms them
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			od_wr_valid_out <= 1'b0;
			od_wr_data_out  <= 8'h0;
		end else begin
			od_wr_valid_out <= rx_take && en_r && idx_r > 9'h2 && hdr_r[0] == FC_MEI
				&& idx_r >= {5'h0, hlen};
			od_wr_data_out  <= rx_take ? rx_data_in : od_wr_data_out;
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= ST_RX;
		end else begin
			case (st_r)
				ST_RX: begin
					if (rx_take && rx_last_in) begin
						st_r <= ST_EVAL;
					end
				end
				ST_EVAL: begin
					if (ovr_pend_r) begin
						st_r <= ST_RX; // overrun message is dropped
					end else if (diag_ok || (is_od && !fmt_ok)) begin
						st_r <= ST_HDR;
					end else if (is_od) begin
						st_r <= ST_OD;
					end else begin
						st_r <= ST_RX;
					end
				end
				ST_OD: begin
					if (od_done_in) begin
						st_r <= ST_HDR;
					end
				end
				ST_HDR: begin
					if (tx_ready_in && tx_idx_r == rsp_len_r - 4'd1) begin
						st_r <= (rd_left_r != 16'h0) ? ST_DAT : ST_RX;
					end
				end
				ST_DAT: begin
					if (od_rd_valid_in && tx_ready_in && rd_left_r == 16'h1) begin
						st_r <= ST_RX;
					end
				end
				default: begin
					st_r <= ST_RX;
				end
			endcase
		end
	end

	// request fields are held until the next accepted transport frame
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			od_req_out    <= 1'b0;
			od_write_out  <= 1'b0;
			od_multi_out  <= 1'b0;
			od_node_out   <= 8'h0;
			od_index_out  <= 16'h0;
			od_sub_out    <= 8'h0;
			od_start_out  <= 16'h0;
			od_count_out  <= 16'h0;
			unhandled_out <= 1'b0;
		end else begin
			od_req_out    <= 1'b0;
			unhandled_out <= st_r == ST_EVAL && !ovr_pend_r && !diag_ok && !is_od;
			if (st_r == ST_EVAL && !ovr_pend_r && !diag_ok && is_od && fmt_ok) begin
				od_req_out   <= 1'b1;
				od_write_out <= pc1[PCB_WR];
				od_multi_out <= pc1[PCB_MULTI];
				od_node_out  <= hdr_r[nb];
				od_index_out <= {hdr_r[nb + 4'd1], hdr_r[nb + 4'd2]};
				od_sub_out   <= hdr_r[nb + 4'd3];
				od_start_out <= {hdr_r[nb + 4'd4], hdr_r[nb + 4'd5]};
				od_count_out <= cntv;
			end
		end
	end

	// ****************************************
	// reply builder
	// ****************************************
	// a good transport reply echoes the header, multi-part flag included, with the read length, or zero for a write, in the count field
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rsp_len_r <= 4'h0;
			rd_left_r <= 16'h0;
			for (int i = 0; i < HDR_N; i++) begin
				rsp_r[i] <= 8'h0;
			end
		end else if (st_r == ST_EVAL && !ovr_pend_r && diag_ok) begin
			rsp_r[0]  <= FC_DIAG;
			rsp_r[1]  <= hdr_r[1];
			rsp_r[2]  <= hdr_r[2];
			rsp_r[3]  <= (sub == SUB_BUSY) ? cnt_w[0][15:8] : (sub == SUB_OVR) ? cnt_w[1][15:8] : hdr_r[3];
			rsp_r[4]  <= (sub == SUB_BUSY) ? cnt_w[0][7:0] : (sub == SUB_OVR) ? cnt_w[1][7:0] : hdr_r[4];
			rsp_len_r <= DIAG_RLEN;
			rd_left_r <= 16'h0;
		end else if (exc_go) begin
			rsp_r[0]  <= FC_MEI | EXC_FLAG;
			rsp_r[1]  <= EXC_EXT;
			rsp_r[2]  <= EXC_LEN[15:8];
			rsp_r[3]  <= EXC_LEN[7:0];
			rsp_r[4]  <= MEI_OD;
			rsp_r[5]  <= EXC_OD;
			rsp_r[6]  <= exc_code[31:24];
			rsp_r[7]  <= exc_code[23:16];
			rsp_r[8]  <= exc_code[15:8];
			rsp_r[9]  <= exc_code[7:0];
			rsp_len_r <= EXC_RLEN;
			rd_left_r <= 16'h0;
		end else if (ok_go) begin
			for (int i = 0; i < HDR_N; i++) begin
				rsp_r[i] <= hdr_r[i];
			end
			rsp_r[hlen - 4'd2] <= od_write_out ? 8'h0 : od_rd_len_in[15:8];
			rsp_r[hlen - 4'd1] <= od_write_out ? 8'h0 : od_rd_len_in[7:0];
			rsp_len_r <= hlen;
			rd_left_r <= od_write_out ? 16'h0 : od_rd_len_in;
		end else if (st_r == ST_DAT && od_rd_valid_in && tx_ready_in) begin
			rd_left_r <= rd_left_r - 16'h1;
		end
	end

	// ****************************************
	// reply stream
	// ****************************************
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_idx_r <= 4'h0;
		end else if (st_r != ST_HDR) begin
			tx_idx_r <= 4'h0;
		end else if (tx_ready_in) begin
			tx_idx_r <= tx_idx_r + 4'h1;
		end
	end

	// read data passes straight through so the od side sees our stall at once
	assign tx_valid_out    = (st_r == ST_HDR) || (st_r == ST_DAT && od_rd_valid_in);
	assign tx_data_out     = (st_r == ST_DAT) ? od_rd_data_in : rsp_r[tx_idx_r];
	assign tx_last_out     = (st_r == ST_HDR) ? (tx_idx_r == rsp_len_r - 4'd1 && rd_left_r == 16'h0)
		: (st_r == ST_DAT && rd_left_r == 16'h1);
	assign od_rd_ready_out = (st_r == ST_DAT) && tx_ready_in;

	// ****************************************
	// register slave and interrupt
	// ****************************************
	// one wait cycle per access keeps the read mux off the bus path
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ack_r            <= 1'b0;
			avs_readdata_out <= 32'h0;
		end else begin
			ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
			if (avs_read_in && !ack_r) begin
				case (avs_address_in)
					REG_CTRL: avs_readdata_out <= {31'h0, en_r};
					REG_BUSY: avs_readdata_out <= {16'h0, cnt_w[0]};
					REG_OVR:  avs_readdata_out <= {16'h0, cnt_w[1]};
					REG_STAT: avs_readdata_out <= {29'h0, stat_r};
					REG_MASK: avs_readdata_out <= {29'h0, mask_r};
					REG_LAST: avs_readdata_out <= {od_node_out, od_sub_out, od_index_out};
					default:  avs_readdata_out <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			en_r   <= CTRL_EN_RST;
			mask_r <= MASK_RST;
		end else if (bus_wr && avs_byteenable_in[0]) begin
			if (avs_address_in == REG_CTRL) begin
				en_r <= avs_writedata_in[CTRL_EN];
			end
			if (avs_address_in == REG_MASK) begin
				mask_r <= avs_writedata_in[IRQ_W-1:0];
			end
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stat_r  <= '0;
			irq_out <= 1'b0;
		end else begin
			stat_r[IRQ_OVR] <= ovr_evt
				| (stat_r[IRQ_OVR] & ~(bus_wr && avs_address_in == REG_STAT && avs_writedata_in[IRQ_OVR]));
			stat_r[IRQ_ERR] <= exc_go
				| (stat_r[IRQ_ERR] & ~(bus_wr && avs_address_in == REG_STAT && avs_writedata_in[IRQ_ERR]));
			stat_r[IRQ_REQ] <= od_req_out
				| (stat_r[IRQ_REQ] & ~(bus_wr && avs_address_in == REG_STAT && avs_writedata_in[IRQ_REQ]));
			irq_out <= |(stat_r & mask_r);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	busy_count_a : assert property (busy_exc_in && !clr_w |=> cnt_w[0] == $past(cnt_w[0]) + 16'h1)
		else $error("busy count did not step");
	count_clear_a : assert property (clr_w |=> cnt_w[0] == 16'h0 && cnt_w[1] == 16'h0)
		else $error("counters not cleared");
	ovr_count_a : assert property (ovr_evt && !ovr_pend_r && !clr_w |=> cnt_w[1] == $past(cnt_w[1]) + 16'h1)
		else $error("overrun count did not step");
	ovr_flag_a : assert property (rx_valid_in && !rx_ready_out |=> ovr_pend_r)
		else $error("overrun not flagged");
	diag_echo_a : assert property (st_r == ST_EVAL && !ovr_pend_r && diag_ok |=>
		rsp_r[0] == FC_DIAG && {rsp_r[1], rsp_r[2]} == $past(sub) && st_r == ST_HDR)
		else $error("diagnostic echo wrong");
	od_frame_a : assert property (od_req_out |-> hdr_r[0] == FC_MEI && hdr_r[1] == MEI_OD && !$past(od_req_out))
		else $error("request from bad frame");
	od_dir_a : assert property (od_req_out |-> od_write_out == pc1[PCB_WR] && od_multi_out == pc1[PCB_MULTI])
		else $error("access direction wrong");
	od_range_a : assert property (od_req_out |-> od_node_out inside {[8'h01:8'h7f]} && od_count_out <= CNT_MAX)
		else $error("field out of range");
	od_exc_a : assert property (st_r == ST_OD && od_done_in && od_err_in |=>
		rsp_r[0] == 8'hab && rsp_r[1] == EXC_EXT && rsp_r[5] == EXC_OD && rsp_len_r == EXC_RLEN)
		else $error("exception reply wrong");
	bus_answer_a : assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("bus answer late");
endmodule // mdt_transport

// *** testbench/mdt_master_model.sv ***
// far-side serial master model: takes the reply stream byte by byte
// assumes: reply bytes handshake on the rising edge of clk_in
`timescale 1ns/1ps
module mdt_master_model (
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	input  wire logic       tx_valid_in,
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_last_in,
	output logic            tx_ready_out
);
	// ****
	// reply capture, {last, data} per byte
	// ****
	logic [8:0] got[$];
	// stall every other cycle so each reply byte after the first has to stand through a wait
	always @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			tx_ready_out <= 1'b0;
		end else begin
			tx_ready_out <= !tx_ready_out;
			if (tx_valid_in && tx_ready_out) begin
				got.push_back({tx_last_in, tx_data_in});
			end
		end
	end
endmodule // mdt_master_model

// *** testbench/mdt_transport_bench.sv ***
// self-checking bench for the diagnostic counter and transport block
// assumes: mdt_pkg, mdt_transport and mdt_master_model compiled first
`timescale 1ns/1ps
module mdt_transport_bench;
	import mdt_pkg::*;
	// ****
	// signals, clock and the object side responder
	// ****
	logic        clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0, rx_valid_in = 1'b0;
	logic        rx_last_in = 1'b0, char_lost_in = 1'b0, restart_in = 1'b0, busy_exc_in = 1'b0;
	logic        od_done_in = 1'b0, od_err_in = 1'b0, err_mode = 1'b0, tx_ready_in, tx_valid_out, tx_last_out;
	logic        avs_waitrequest_out, irq_out, rx_ready_out, od_req_out, od_write_out, od_multi_out;
	logic        od_rd_ready_out, od_wr_valid_out, unhandled_out;
	logic [7:0]  od_wr_data_out;
	logic [31:0] wr_word = 32'h0;
	int          n_wr = 0, n_unh = 0;
	logic [4:0]  avs_address_in = 5'h00;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd;
	logic [7:0]  rx_data_in = 8'h00, od_rd_data_in = 8'h37, tx_data_out, od_node_out, od_sub_out;
	logic [15:0] od_rd_len_in = 16'h0002, od_index_out, od_start_out, od_count_out;
	logic [7:0]  exc[$] = '{8'hab, 8'hff, 8'h00, 8'h06, 8'h0d, 8'hce};
	int          err_count = 0, n_tests = 0;
	always #2 clk_in = !clk_in;
	// object side answers one cycle after each request, failing only when told to
	always @(posedge clk_in) begin
		od_done_in <= od_req_out;
		od_err_in <= od_req_out && err_mode;
		if (od_rd_ready_out) begin
			od_rd_data_in <= od_rd_data_in + 8'h01;
		end
		// write data bytes and unserved frames are tallied for the scenarios
		if (od_wr_valid_out) begin
			wr_word <= {wr_word[23:0], od_wr_data_out};
			n_wr <= n_wr + 1;
		end
		if (unhandled_out) begin
			n_unh <= n_unh + 1;
		end
	end
	mdt_transport uut (.clk_in, .resetn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
		.avs_byteenable_in(4'hf), .avs_readdata_out, .avs_waitrequest_out, .irq_out, .rx_valid_in, .rx_data_in,
		.rx_last_in, .rx_ready_out, .char_lost_in, .restart_in, .busy_exc_in, .tx_valid_out, .tx_data_out,
		.tx_last_out, .tx_ready_in, .od_req_out, .od_write_out, .od_multi_out, .od_node_out, .od_index_out,
		.od_sub_out, .od_start_out, .od_count_out, .od_wr_valid_out, .od_wr_data_out, .od_done_in,
		.od_err_in, .od_err_code_in(32'h12345678), .od_rd_len_in, .od_rd_valid_in(1'b1), .od_rd_data_in,
		.od_rd_ready_out, .unhandled_out);
	mdt_master_model mm (.clk_in, .resetn_in, .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out),
		.tx_last_in(tx_last_out), .tx_ready_out(tx_ready_in));
	// ****
	// shared tasks
	// ****
	task automatic test_done();
		$display("mismatches %0d, checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask
	// a wait that ran out of cycles ends the run at once
	task automatic tmo(input int i);
		if (i >= 300) begin
			$display("MISMATCH wait expected handshake seen timeout");
			err_count++;
			test_done();
		end
	endtask
	// one avalon access, request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		do begin
			@(posedge clk_in);
			i++;
		end while (avs_waitrequest_out !== 1'b0 && i < 300);
		rd = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge clk_in);
		tmo(i);
	endtask
	task automatic send(input logic [7:0] f[$]);
		int i = 0;
		foreach (f[k]) begin
			rx_valid_in <= 1'b1;
			rx_data_in <= f[k];
			rx_last_in <= (k == f.size() - 1);
			do begin
				@(posedge clk_in);
				i++;
			end while (rx_ready_out !== 1'b1 && i < 300);
		end
		rx_valid_in <= 1'b0;
		rx_last_in <= 1'b0;
		@(posedge clk_in);
		tmo(i);
	endtask
	// last flag must mark exactly the final expected byte
	task automatic reply(input logic [7:0] e[$]);
		int i = 0;
		while (mm.got.size() < e.size() && i < 300) begin
			@(posedge clk_in);
			i++;
		end
		tmo(i);
		foreach (e[k]) begin
			chk("reply byte", {(k == e.size() - 1), e[k]}, mm.got[k]);
		end
		mm.got.delete();
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_busy();
		repeat (3) begin
			busy_exc_in <= 1'b1;
			@(posedge clk_in);
			busy_exc_in <= 1'b0;
			@(posedge clk_in);
		end
		send('{FC_DIAG, 8'h00, 8'h11, 8'h00, 8'h00});
		reply('{FC_DIAG, 8'h00, 8'h11, 8'h00, 8'h03});
		restart_in <= 1'b1;
		@(posedge clk_in);
		restart_in <= 1'b0;
		bus(1'b0, REG_BUSY, 32'h0);
		chk("busy after restart", 32'h0, rd);
		// one more event, then the clear-counters subfunction must zero it again
		busy_exc_in <= 1'b1;
		@(posedge clk_in);
		busy_exc_in <= 1'b0;
		bus(1'b0, REG_BUSY, 32'h0);
		chk("busy after one event", 32'h1, rd);
		send('{FC_DIAG, 8'h00, 8'h0a, 8'h00, 8'h00});
		reply('{FC_DIAG, 8'h00, 8'h0a, 8'h00, 8'h00});
		bus(1'b0, REG_BUSY, 32'h0);
		chk("busy after clear request", 32'h0, rd);
		// a subfunction not served here gets no reply, only the unhandled pulse
		send('{FC_DIAG, 8'h00, 8'h0b, 8'h00, 8'h00});
		repeat (2) @(posedge clk_in);
		chk("unhandled pulses", 32'h1, n_unh);
		chk("no reply to unserved", 32'h0, mm.got.size());
	endtask
	// a lost character drops the next frame and is counted once
	task automatic t_overrun();
		bus(1'b1, REG_MASK, 32'h1);
		char_lost_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		char_lost_in <= 1'b0;
		send('{FC_DIAG, 8'h00, 8'h11, 8'h00, 8'h00});
		send('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h00});
		reply('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h01});
		chk("irq on overrun", 32'h1, irq_out);
		bus(1'b1, REG_STAT, 32'h1);
		bus(1'b0, REG_STAT, 32'h0);
		chk("status after clear", 32'h0, rd);
		chk("irq after clear", 32'h0, irq_out);
		bus(1'b1, REG_CTRL, 32'h3);
		bus(1'b0, REG_OVR, 32'h0);
		chk("overrun after clear", 32'h0, rd);
		// a byte offered while the reply is still going out is an overrun too
		send('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h00});
		rx_valid_in <= 1'b1;
		@(posedge clk_in);
		rx_valid_in <= 1'b0;
		reply('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h00});
		send('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h00});
		send('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h00});
		reply('{FC_DIAG, 8'h00, 8'h12, 8'h00, 8'h01});
		bus(1'b0, 5'h18, 32'h0);
		chk("unmapped read", 32'h0, rd);
	endtask
	// two control bytes plus counter byte, write of four data bytes
	task automatic t_write();
		logic [7:0] h[$] = '{FC_MEI, MEI_OD, 8'h61, 8'h00, 8'h00, 8'h07, 8'h01, 8'h20, 8'h31, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h04};
		send({h, 8'he8, 8'h03, 8'h00, 8'h00});
		h[13] = 8'h00;
		reply(h);
		chk("write fields", {1'b1, 1'b0, 8'h01, 16'h2031}, {od_write_out, od_multi_out, od_node_out, od_index_out});
		chk("write count", 32'h4, od_count_out);
		chk("write data", 32'he8030000, wr_word);
		chk("write bytes", 32'h4, n_wr);
	endtask
	task automatic t_read();
		logic [7:0] h[$] = '{FC_MEI, MEI_OD, 8'h80, 8'h00, 8'h01, 8'h60, 8'h41, 8'h05, 8'h12, 8'h34, 8'h00, 8'h02};
		send(h);
		reply({h, 8'h37, 8'h38});
		chk("read fields", {1'b0, 1'b1, 8'h05, 16'h1234}, {od_write_out, od_multi_out, od_sub_out, od_start_out});
		chk("read count", 32'h2, od_count_out);
	endtask
	// malformed frames and a failing object access give the exception reply
	task automatic t_fault();
		logic [7:0] g[$] = '{FC_MEI, MEI_OD, 8'h00, 8'h00, 8'h01, 8'h60, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
		logic [7:0] f[$];
		logic [7:0] bad[7][2] = '{'{4, 8'h80}, '{4, 8'h00}, '{11, 8'hfe}, '{3, 8'h01}, '{2, 8'h10}, '{2, 8'h04},
			'{2, 8'h02}};
		foreach (bad[k]) begin
			f = g;
			f[bad[k][0]] = bad[k][1];
			send(f);
			reply({exc, 8'hff, 8'hff, 8'h00, 8'h03});
		end
		err_mode <= 1'b1;
		send(g);
		reply({exc, 8'h12, 8'h34, 8'h56, 8'h78});
		err_mode <= 1'b0;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (3) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(posedge clk_in);
		bus(1'b0, REG_CTRL, 32'h0);
		chk("ctrl reset", 32'h1, rd);
		t_busy();
		t_overrun();
		t_write();
		t_read();
		t_fault();
		test_done();
	end
endmodule // mdt_transport_bench
